//--- shared/ocf_cfg.svh
`ifndef OCF_CFG_SVH
`define OCF_CFG_SVH

// ----------------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------------
`define OCF_CODE_TIMING_CFG   8'hC8
`define OCF_CODE_RESPONSE_CFG 8'hCA

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define OCF_RESPONSE_RST      8'h00
`define OCF_TIMING_RST        8'h00
`define OCF_UNMAPPED_RDATA    8'h00

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define OCF_RESP_MSB          7
`define OCF_RESP_LSB          6
`define OCF_RETRY_MSB         5
`define OCF_RETRY_LSB         3
`define OCF_DELAY_MSB         2
`define OCF_DELAY_LSB         0
`define OCF_IUNIT_MSB         3
`define OCF_IUNIT_LSB         2

// ----------------------------------------------------------------------------
// field codes
// ----------------------------------------------------------------------------
`define OCF_RESP_IGNORE       2'h0
`define OCF_RESP_RETRY        2'h3
`define OCF_RETRY_NONE        3'h0
`define OCF_RETRY_FOREVER     3'h7

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define OCF_CLK_HZ            50000000
`define OCF_UNIT_BASE_MS      1
`define OCF_MS_CYCLES         ((`OCF_CLK_HZ / 1000) * `OCF_UNIT_BASE_MS)
`define OCF_UNIT0_MS          9'h001
`define OCF_UNIT1_MS          9'h004
`define OCF_UNIT2_MS          9'h010
`define OCF_UNIT3_MS          9'h100

`endif

//--- shared/ocf_pkg.sv
package ocf_pkg;

  // ----------------------------------------------------------------------------
  // response configuration byte
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] response;
    logic [2:0] retries;
    logic [2:0] delay;
  } ocf_resp_t;

  // ----------------------------------------------------------------------------
  // controller states
  // ----------------------------------------------------------------------------
  typedef enum logic [4:0] {
    OCF_IDLE    = 5'h01,
    OCF_RUN     = 5'h02,
    OCF_LIMIT   = 5'h04,
    OCF_WAIT    = 5'h08,
    OCF_LATCHED = 5'h10
  } ocf_state_t;

endpackage : ocf_pkg

//--- logic/ocf_unit_tick.sv
`timescale 1ns/1ps
`include "ocf_cfg.svh"

module ocf_unit_tick #(
  parameter int MS_CYCLES = `OCF_MS_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       restart,
  input  wire logic [1:0] unit_sel,
  output logic            unit_tick
);

  localparam int MSW = $clog2(MS_CYCLES);

  generate
    if (MS_CYCLES < 2) begin : g_chk
      $error("ocf_unit_tick: MS_CYCLES must be at least 2");
    end
  endgenerate

  logic [MSW-1:0] ms_cnt_r;
  logic [8:0]     ms_in_unit_r;
  logic           ms_tick;
  logic [8:0]     unit_ms;

  // ----------------------------------------------------------------------------
  // time unit length in milliseconds
  // ----------------------------------------------------------------------------
  function automatic logic [8:0] unit_len(input logic [1:0] sel);
    case (sel)
      2'h0:    unit_len = `OCF_UNIT0_MS;
      2'h1:    unit_len = `OCF_UNIT1_MS;
      2'h2:    unit_len = `OCF_UNIT2_MS;
      default: unit_len = `OCF_UNIT3_MS;
    endcase
  endfunction : unit_len

  assign ms_tick = (ms_cnt_r == MSW'(MS_CYCLES - 1));
  assign unit_ms = unit_len(unit_sel);

  // ----------------------------------------------------------------------------
  // millisecond prescaler
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst || restart || ms_tick) begin
      ms_cnt_r <= '0;
    end else begin
      ms_cnt_r <= ms_cnt_r + MSW'(1);
    end
  end

  // ----------------------------------------------------------------------------
  // unit counter
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst || restart) begin
      ms_in_unit_r <= 9'h000;
      unit_tick    <= 1'b0;
    end else begin
      unit_tick <= 1'b0;
      if (ms_tick) begin
        if (ms_in_unit_r + 9'h001 >= unit_ms) begin
          ms_in_unit_r <= 9'h000;
          unit_tick    <= 1'b1;
        end else begin
          ms_in_unit_r <= ms_in_unit_r + 9'h001;
        end
      end
    end
  end

endmodule : ocf_unit_tick

//--- logic/ocf_retry_ctrl.sv
`timescale 1ns/1ps
`include "ocf_cfg.svh"

module ocf_retry_ctrl
  import ocf_pkg::*;
#(
  parameter int MS_CYCLES = `OCF_MS_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [7:0] cmd_code,
  input  wire logic       cmd_wr,
  input  wire logic [7:0] cmd_wdata,
  output logic      [7:0] cmd_rdata,
  input  wire logic       clear_faults,
  input  wire logic       operation_on,
  input  wire logic       control_pin,
  input  wire logic       bias_ok,
  input  wire logic       other_fault,
  input  wire logic       oc_detect,
  output logic            output_enable,
  output logic            fast_limit_sel,
  output logic            current_limit_active,
  output logic            oc_fault_status,
  output logic            host_alert,
  output logic      [2:0] attempt_count
);

  ocf_resp_t  resp_cfg_r;
  logic [7:0] timing_cfg_r;
  ocf_state_t state_r;
  ocf_state_t state_nxt;
  logic [1:0] oc_sync_r;
  logic [1:0] ctl_sync_r;
  logic       oc_prev_r;
  logic [7:0] del_cnt_r;
  logic       oc;
  logic       oc_rise;
  logic       run_req;
  logic       unit_tick;
  logic       delay_done;
  logic       restart_tick;
  logic       may_retry;

  // ----------------------------------------------------------------------------
  // delay code to unit count minus one
  // ----------------------------------------------------------------------------
  function automatic logic [7:0] delay_last(input logic [2:0] code);
    delay_last = 8'((9'h001 << code) - 9'h001);
  endfunction : delay_last

  // ----------------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      oc_sync_r  <= 2'h0;
      ctl_sync_r <= 2'h0;
      oc_prev_r  <= 1'b0;
    end else begin
      oc_sync_r  <= {oc_sync_r[0], oc_detect};
      ctl_sync_r <= {ctl_sync_r[0], control_pin};
      oc_prev_r  <= oc_sync_r[1];
    end
  end

  assign oc      = oc_sync_r[1];
  assign oc_rise = oc && !oc_prev_r;
  assign run_req = operation_on && ctl_sync_r[1] && bias_ok && !other_fault;

  // ----------------------------------------------------------------------------
  // command registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      resp_cfg_r   <= ocf_resp_t'(`OCF_RESPONSE_RST);
      timing_cfg_r <= `OCF_TIMING_RST;
    end else if (cmd_wr) begin
      if (cmd_code == `OCF_CODE_RESPONSE_CFG) begin
        resp_cfg_r <= ocf_resp_t'(cmd_wdata);
      end
      if (cmd_code == `OCF_CODE_TIMING_CFG) begin
        timing_cfg_r <= cmd_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cmd_rdata <= `OCF_UNMAPPED_RDATA;
    end else begin
      case (cmd_code)
        `OCF_CODE_RESPONSE_CFG: cmd_rdata <= resp_cfg_r;
        `OCF_CODE_TIMING_CFG:   cmd_rdata <= timing_cfg_r;
        default:                cmd_rdata <= `OCF_UNMAPPED_RDATA;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // delay timer
  // ----------------------------------------------------------------------------
  assign restart_tick = (state_nxt != state_r);

  ocf_unit_tick #(
    .MS_CYCLES (MS_CYCLES)
  ) u_tick (
    .clk       (clk),
    .nrst      (nrst),
    .restart   (restart_tick),
    .unit_sel  (timing_cfg_r[`OCF_IUNIT_MSB:`OCF_IUNIT_LSB]),
    .unit_tick (unit_tick)
  );

  assign delay_done = unit_tick && (del_cnt_r == delay_last(resp_cfg_r.delay));

  always_ff @(posedge clk) begin
    if (!nrst || restart_tick) begin
      del_cnt_r <= 8'h00;
    end else if (unit_tick) begin
      del_cnt_r <= del_cnt_r + 8'h01;
    end
  end

  assign may_retry = (resp_cfg_r.retries == `OCF_RETRY_FOREVER) ||
                     (attempt_count < resp_cfg_r.retries);

  // ----------------------------------------------------------------------------
  // response state machine
  // ----------------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      OCF_IDLE: begin
        if (run_req) begin
          state_nxt = OCF_RUN;
        end
      end
      OCF_RUN: begin
        if (oc && resp_cfg_r.response == `OCF_RESP_RETRY) begin
          state_nxt = OCF_LIMIT;
        end
      end
      OCF_LIMIT: begin
        if (!oc) begin
          state_nxt = OCF_RUN;
        end else if (delay_done) begin
          if (resp_cfg_r.retries == `OCF_RETRY_NONE) begin
            state_nxt = OCF_LATCHED;
          end else if (may_retry) begin
            state_nxt = OCF_WAIT;
          end else begin
            state_nxt = OCF_LATCHED;
          end
        end
      end
      OCF_WAIT: begin
        if (delay_done) begin
          state_nxt = OCF_RUN;
        end
      end
      OCF_LATCHED: begin
        if (clear_faults) begin
          state_nxt = OCF_IDLE;
        end
      end
      default: state_nxt = OCF_IDLE;
    endcase
    if (!run_req) begin
      state_nxt = OCF_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r <= OCF_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------------------
  // attempt counter
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst || !run_req || clear_faults) begin
      attempt_count <= 3'h0;
    end else if (state_r == OCF_WAIT && state_nxt == OCF_RUN &&
                 attempt_count != 3'h7) begin
      attempt_count <= attempt_count + 3'h1;
    end
  end

  // ----------------------------------------------------------------------------
  // power stage outputs
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      output_enable        <= 1'b0;
      fast_limit_sel       <= 1'b0;
      current_limit_active <= 1'b0;
    end else begin
      output_enable        <= (state_nxt == OCF_RUN) || (state_nxt == OCF_LIMIT);
      fast_limit_sel       <= (resp_cfg_r.response == `OCF_RESP_RETRY);
      current_limit_active <= oc && ((state_nxt == OCF_RUN) ||
                                     (state_nxt == OCF_LIMIT));
    end
  end

  // ----------------------------------------------------------------------------
  // status and notification, set wins over clear
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      oc_fault_status <= 1'b0;
      host_alert      <= 1'b0;
    end else if (oc_rise) begin
      oc_fault_status <= 1'b1;
      host_alert      <= 1'b1;
    end else if (clear_faults) begin
      oc_fault_status <= 1'b0;
      host_alert      <= 1'b0;
    end
  end

endmodule : ocf_retry_ctrl

//--- dv/ocf_retry_ctrl_sva.sv
`timescale 1ns/1ps
module ocf_retry_ctrl_sva #(
  parameter int MS_CYCLES = 10
) (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic [7:0] cmd_code,
  input wire logic       cmd_wr,
  input wire logic [7:0] cmd_wdata,
  input wire logic       clear_faults,
  input wire logic       operation_on,
  input wire logic       control_pin,
  input wire logic       bias_ok,
  input wire logic       other_fault,
  input wire logic       oc_detect,
  input wire logic       output_enable,
  input wire logic       current_limit_active,
  input wire logic       oc_fault_status,
  input wire logic       host_alert,
  input wire logic [2:0] attempt_count
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [7:0] resp_r;
  logic [7:0] tim_r;
  int         off_r;
  int         lim_r;
  int         t;
  logic [2:0] ctl_q;
  logic       run_ok;
  // control pin reaches the state machine three edges late
  always_ff @(posedge clk) begin
    ctl_q <= {ctl_q[1:0], control_pin};
  end
  assign run_ok = operation_on && bias_ok && !other_fault && ctl_q[2];
  always_ff @(posedge clk) begin
    if (!nrst) begin
      resp_r <= 8'h00;
      tim_r  <= 8'h00;
    end else if (cmd_wr && cmd_code == 8'hCA) begin
      resp_r <= cmd_wdata;
    end else if (cmd_wr && cmd_code == 8'hC8) begin
      tim_r <= cmd_wdata;
    end
  end
  // run lengths of the off and the limiting phases
  always_ff @(posedge clk) begin
    off_r <= output_enable ? 0 : off_r + 1;
    lim_r <= current_limit_active ? lim_r + 1 : 0;
  end
  always_comb t = (1 << resp_r[2:0]) * MS_CYCLES * (tim_r[3:2] == 2'h3 ? 256 : 1 << (2 * tim_r[3:2]));
  chk_status_set: assert property ($rose(oc_detect) ##0 oc_detect [*5] |->
    oc_fault_status && host_alert) else $error("status or alert not set");
  chk_status_sticky: assert property ($fell(oc_fault_status) |->
    $past(clear_faults)) else $error("status dropped without clear");
  chk_ignore_on: assert property (resp_r[7:6] == 2'h0 && output_enable && operation_on |=>
    output_enable) else $error("output dropped in ignore mode");
  chk_limit_time: assert property ($fell(output_enable) && run_ok && resp_r[7:6] == 2'h3 |->
    lim_r >= t - 2 && lim_r <= t + 4) else $error("limiting time wrong");
  chk_no_retry: assert property ($fell(output_enable) && resp_r[7:3] == 5'h18 && operation_on |=>
    !output_enable until clear_faults) else $error("restart without retries");
  chk_attempt_bound: assert property (resp_r[5:3] != 3'h7 |->
    attempt_count <= resp_r[5:3]) else $error("too many restarts");
  chk_restart_gap: assert property ($changed(attempt_count) && attempt_count != 3'h0 |->
    off_r >= t - 2 && off_r <= t + 4) else $error("restart spacing wrong");
  chk_attempt_clear: assert property (clear_faults || !operation_on || !bias_ok || other_fault |=>
    attempt_count == 3'h0) else $error("attempt count not cleared");
  cov_exhausted: cover property (attempt_count == 3'h6 && !output_enable);
  cov_forever: cover property (attempt_count == 3'h7);
  cov_ignore: cover property (resp_r[7:6] == 2'h0 && current_limit_active);
endmodule : ocf_retry_ctrl_sva

//--- dv/ocf_host_model.sv
`timescale 1ns/1ps
module ocf_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] cmd_rdata,
  output logic      [7:0] cmd_code,
  output logic            cmd_wr,
  output logic      [7:0] cmd_wdata
);
  initial begin
    cmd_code  = 8'h00;
    cmd_wr    = 1'b0;
    cmd_wdata = 8'h00;
  end
  // data is scrambled after the strobe so a late sample cannot pass
  task automatic wr(input logic [7:0] code, input logic [7:0] data);
    @(negedge clk);
    cmd_code  = code;
    cmd_wdata = data;
    cmd_wr    = 1'b1;
    @(negedge clk);
    cmd_wr    = 1'b0;
    cmd_wdata = ~data;
  endtask : wr
  task automatic rd(input logic [7:0] code, output logic [7:0] data);
    @(negedge clk);
    cmd_code = code;
    @(negedge clk);
    data = cmd_rdata;
  endtask : rd
endmodule : ocf_host_model

//--- dv/ocf_retry_ctrl_tb.sv
`timescale 1ns/1ps
module ocf_retry_ctrl_tb;
  logic       clk, nrst, clear_faults, operation_on, oc_detect, cmd_wr;
  logic       control_pin, bias_ok, other_fault;
  logic [7:0] cmd_code, cmd_wdata, cmd_rdata, rd_v;
  logic       output_enable, fast_limit_sel, current_limit_active;
  logic       oc_fault_status, host_alert;
  logic [2:0] attempt_count;
  int         fails = 0;
  int         num_checks = 0;
  ocf_retry_ctrl #(.MS_CYCLES(10)) i_dut (
    .clk, .nrst, .cmd_code, .cmd_wr, .cmd_wdata, .cmd_rdata, .clear_faults,
    .operation_on, .control_pin, .bias_ok, .other_fault,
    .oc_detect, .output_enable, .fast_limit_sel, .current_limit_active,
    .oc_fault_status, .host_alert, .attempt_count
  );
  ocf_host_model i_host (.clk, .cmd_rdata, .cmd_code, .cmd_wr, .cmd_wdata);
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", n, e, s);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict
  task automatic tick(int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic clr();
    oc_detect = 1'b0;
    tick(3);
    clear_faults = 1'b1;
    tick(1);
    clear_faults = 1'b0;
    tick(4);
    chk("status", oc_fault_status, 8'h00);
    chk("running", output_enable, 8'h01);
  endtask : clr
  // wait long enough for every allowed restart to fail
  task automatic fault(logic [7:0] cfg, logic [1:0] u, int n);
    int w;
    i_host.wr(8'hCA, cfg);
    i_host.wr(8'hC8, {4'h0, u, 2'h0});
    w = (n + 1) * 2 * (1 << cfg[2:0]) * (u == 2'h3 ? 256 : 1 << (2 * u)) * 10 + 60;
    oc_detect = 1'b1;
    tick(w);
    chk("off", output_enable, 8'h00);
    chk("attempts", attempt_count, n[7:0]);
    chk("status", oc_fault_status, 8'h01);
    chk("alert", host_alert, 8'h01);
    chk("fast sel", fast_limit_sel, 8'h01);
    clr();
  endtask : fault
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #1_500_000;
    fails++;
    give_verdict();
  end
  initial begin
    nrst = 1'b0;
    clear_faults = 1'b0;
    operation_on = 1'b1;
    control_pin = 1'b1;
    bias_ok = 1'b1;
    other_fault = 1'b0;
    oc_detect = 1'b0;
    tick(5);
    nrst = 1'b1;
    i_host.rd(8'hCA, rd_v);
    chk("resp reset", rd_v, 8'h00);
    i_host.rd(8'hC8, rd_v);
    chk("timing reset", rd_v, 8'h00);
    i_host.wr(8'hCA, 8'hA5);
    i_host.wr(8'hC8, 8'h0C);
    i_host.wr(8'h55, 8'hFF);
    i_host.rd(8'hCA, rd_v);
    chk("resp", rd_v, 8'hA5);
    i_host.rd(8'hC8, rd_v);
    chk("timing", rd_v, 8'h0C);
    i_host.rd(8'h55, rd_v);
    chk("unmapped", rd_v, 8'h00);
    i_host.wr(8'hCA, 8'h00);
    oc_detect = 1'b1;
    tick(30);
    chk("on", output_enable, 8'h01);
    chk("limiting", current_limit_active, 8'h01);
    chk("fast sel", fast_limit_sel, 8'h00);
    chk("status", oc_fault_status, 8'h01);
    chk("alert", host_alert, 8'h01);
    clr();
    fault(8'hC7, 2'h0, 0);
    for (int k = 1; k < 7; k++) begin
      fault({2'h3, k[2:0], k[2:0]}, 2'h0, k);
    end
    for (int u = 0; u < 4; u++) begin
      fault(8'hC8, u[1:0], 1);
    end
    i_host.wr(8'hCA, 8'hF8);
    i_host.wr(8'hC8, 8'h00);
    oc_detect = 1'b1;
    // each way of commanding off ends unlimited retrying
    for (int s = 0; s < 4; s++) begin
      tick(600);
      chk("forever", attempt_count, 8'h07);
      operation_on = (s != 0);
      control_pin  = (s != 1);
      bias_ok      = (s != 2);
      other_fault  = (s == 3);
      tick(4);
      chk("stopped", output_enable, 8'h00);
      chk("count cleared", attempt_count, 8'h00);
      operation_on = 1'b1;
      control_pin  = 1'b1;
      bias_ok      = 1'b1;
      other_fault  = 1'b0;
    end
    give_verdict();
  end
endmodule : ocf_retry_ctrl_tb
bind ocf_retry_ctrl ocf_retry_ctrl_sva #(.MS_CYCLES(MS_CYCLES)) i_sva (
  .clk, .nrst, .cmd_code, .cmd_wr, .cmd_wdata, .clear_faults, .operation_on, .oc_detect,
  .control_pin, .bias_ok, .other_fault,
  .output_enable, .current_limit_active, .oc_fault_status, .host_alert, .attempt_count
);
